// >>> rtl/trps_top.sv
/*
 * control core of a three-rail switching regulator: enable
 * sequencing of reference and oscillator, two buck channels and
 * one in-phase boost channel, and logic supply source selection.
 * assumes comparator results arrive as asynchronous digital levels
 * from the analog front end, and a free-running 40 mhz clock.
 */
`timescale 1ns/1ps
`include "trps_consts.svh"
module trps_top
  import trps_pkg::*;
#(
  parameter int SS_CYC  = `TRPS_SS_CYC,     // soft-start length
  parameter int REF_CYC = `TRPS_REF_SETTLE  // reference settle
) (
  input  wire logic clk_i,                  // core clock
  input  wire logic resetn_i,               // sync reset, low
  input  wire logic ce_i,                   // clock enable
  // enables
  input  wire logic low_rail_enable_i,      // low rail run
  input  wire logic mid_rail_enable_i,      // mid rail run
  input  wire logic boost_enable_i,         // boost rail run
  // low rail comparators
  input  wire logic low_rail_ontime_i,      // pwm on-time end
  input  wire logic low_rail_skip_i,        // 20 mv trip
  input  wire logic low_rail_limit_i,       // 120 mv limit
  input  wire logic low_rail_zero_i,        // current zero
  input  wire logic low_rail_below_i,       // below regulation
  // mid rail comparators
  input  wire logic mid_rail_ontime_i,      // pwm on-time end
  input  wire logic mid_rail_skip_i,        // 20 mv trip
  input  wire logic mid_rail_limit_i,       // 120 mv limit
  input  wire logic mid_rail_zero_i,        // current zero
  input  wire logic mid_rail_below_i,       // below regulation
  input  wire logic mid_rail_switchover_i,  // feedback above 4.5 v
  // boost comparators
  input  wire logic boost_ontime_i,         // pwm on-time end
  input  wire logic boost_skip_i,           // 100 mv trip
  input  wire logic boost_limit_i,          // 410 mv limit
  input  wire logic boost_below_i,          // below regulation
  // gates
  output logic      low_rail_high_gate_o,   // low rail high side
  output logic      low_rail_low_gate_o,    // low rail low side
  output logic      mid_rail_high_gate_o,   // mid rail high side
  output logic      mid_rail_low_gate_o,    // mid rail low side
  output logic      boost_high_gate_o,      // boost high side
  output logic      boost_low_gate_o,       // boost low side
  // housekeeping
  output logic      reference_enable_o,     // reference on
  output logic      oscillator_run_o,       // oscillator on
  output logic      linear_regulator_en_o,  // linear regulator on
  output logic      logic_supply_rail_sel_o, // rail from converter
  output logic [2:0] pulse_skip_state_o     // per channel skip
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [7:0] OSC_LAST = 8'(`TRPS_OSC_CYC - 1);
  localparam logic [3:0] REF_LAST = 4'(REF_CYC - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  trps_top_s          r_reg;        // whole core state
  trps_top_s          r_next;       // its next value
  logic [17:0]        raw;          // asynchronous inputs
  logic [2:0]         en;           // synchronised enables
  logic               any_en;       // some rail requested
  logic               running;      // sequencer finished
  logic [4:0]         low_c;        // low rail comparators
  logic [4:0]         mid_c;        // mid rail comparators
  logic [3:0]         bst_c;        // boost comparators
  logic               sw_c;         // switchover comparator

  // ----------------------------------------------------------------
  // input gathering
  // ----------------------------------------------------------------
  // every comparator and enable input is bundled so one synchroniser serves all;
  // the limit pins are sampled too, but the raw level also cuts the high
  // gate, and on the boost both gates, directly inside the channel
  assign raw = {mid_rail_switchover_i,
                boost_below_i, boost_limit_i,
                boost_skip_i, boost_ontime_i,
                mid_rail_below_i, mid_rail_zero_i,
                mid_rail_limit_i, mid_rail_skip_i,
                mid_rail_ontime_i,
                low_rail_below_i, low_rail_zero_i,
                low_rail_limit_i, low_rail_skip_i,
                low_rail_ontime_i,
                boost_enable_i, mid_rail_enable_i,
                low_rail_enable_i};

  // only the second stage is ever read by logic
  assign en     = r_reg.sync2[2:0];
  assign low_c  = r_reg.sync2[7:3];
  assign mid_c  = r_reg.sync2[12:8];
  assign bst_c  = r_reg.sync2[16:13];
  assign sw_c   = r_reg.sync2[17];
  assign any_en = |en;

  // switching is only allowed once the oscillator has been started
  assign running = (r_reg.seq == SEQ_RUN) & r_reg.osc_run;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_next       = r_reg;
    r_next.sync1 = raw;
    r_next.sync2 = r_reg.sync1;
    r_next.tick  = 1'b0;

    // power-up and shutdown sequencing
    unique case (r_reg.seq)
      SEQ_OFF: begin
        // shutdown: reference and oscillator both stopped
        if (any_en) begin
          r_next.seq     = SEQ_REF;
          r_next.ref_en  = 1'b1;
          r_next.ref_cnt = '0;
        end
      end
      SEQ_REF: begin
        // give the reference time to settle before clocking
        r_next.ref_cnt = r_reg.ref_cnt + 4'h1;
        if (r_reg.ref_cnt >= REF_LAST) begin
          r_next.seq     = SEQ_RUN;
          r_next.osc_run = 1'b1;
          r_next.osc_cnt = '0;
        end
      end
      SEQ_RUN: begin
        // oscillator divides the core clock to the switching rate
        if (r_reg.osc_cnt >= OSC_LAST) begin
          r_next.osc_cnt = '0;
          r_next.tick    = 1'b1;
        end else begin
          r_next.osc_cnt = r_reg.osc_cnt + 8'h1;
        end
      end
    endcase

    // dropping every enable wins over any phase in progress
    if (!any_en) begin
      r_next.seq     = SEQ_OFF;
      r_next.ref_en  = 1'b0;
      r_next.osc_run = 1'b0;
      r_next.osc_cnt = '0;
      r_next.ref_cnt = '0;
      r_next.tick    = 1'b0;
    end

    // logic rail source follows the synchronised switchover level;
    // hysteresis lives in the analog comparator, not here
    r_next.vl_sw = sw_c;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // one register for the whole record; a low clock enable freezes
  // sequencer, oscillator and synchronisers alike
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // low rail buck channel
  // ----------------------------------------------------------------
  // each channel owns its soft-start, so rails ramp independently
  trps_chan #(
    .IS_BOOST (1'b0),
    .SS_CYC   (SS_CYC)
  ) u_low (
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .ce_i          (ce_i),
    .run_i         (running & en[0]),
    .tick_i        (r_reg.tick),
    .ontime_trip_i (low_c[0]),
    .skip_trip_i   (low_c[1]),
    .limit_sync_i  (low_c[2]),
    .limit_raw_i   (low_rail_limit_i),
    .zero_i        (low_c[3]),
    .below_i       (low_c[4]),
    .hi_o          (low_rail_high_gate_o),
    .lo_o          (low_rail_low_gate_o),
    .psm_o         (pulse_skip_state_o[0])
  );

  // ----------------------------------------------------------------
  // mid rail buck channel
  // ----------------------------------------------------------------
  trps_chan #(
    .IS_BOOST (1'b0),
    .SS_CYC   (SS_CYC)
  ) u_mid (
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .ce_i          (ce_i),
    .run_i         (running & en[1]),
    .tick_i        (r_reg.tick),
    .ontime_trip_i (mid_c[0]),
    .skip_trip_i   (mid_c[1]),
    .limit_sync_i  (mid_c[2]),
    .limit_raw_i   (mid_rail_limit_i),
    .zero_i        (mid_c[3]),
    .below_i       (mid_c[4]),
    .hi_o          (mid_rail_high_gate_o),
    .lo_o          (mid_rail_low_gate_o),
    .psm_o         (pulse_skip_state_o[1])
  );

  // ----------------------------------------------------------------
  // boost channel
  // ----------------------------------------------------------------
  // freewheeling runs through diodes, so no zero-current input is
  // needed; the port is tied off
  trps_chan #(
    .IS_BOOST (1'b1),
    .SS_CYC   (SS_CYC)
  ) u_boost (
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .ce_i          (ce_i),
    .run_i         (running & en[2]),
    .tick_i        (r_reg.tick),
    .ontime_trip_i (bst_c[0]),
    .skip_trip_i   (bst_c[1]),
    .limit_sync_i  (bst_c[2]),
    .limit_raw_i   (boost_limit_i),
    .zero_i        (1'b0),
    .below_i       (bst_c[3]),
    .hi_o          (boost_high_gate_o),
    .lo_o          (boost_low_gate_o),
    .psm_o         (pulse_skip_state_o[2])
  );

  // ----------------------------------------------------------------
  // housekeeping outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign reference_enable_o      = r_reg.ref_en;
  assign oscillator_run_o        = r_reg.osc_run;
  assign logic_supply_rail_sel_o = r_reg.vl_sw;
  assign linear_regulator_en_o   = ~r_reg.vl_sw;

endmodule // trps_top

// >>> include/trps_consts.svh
/*
 * timing and sizing constants of the triple-rail pwm sequencer.
 * assumes a 40 mhz core clock; all counts but the reference settle are derived from it here.
 */
`ifndef TRPS_CONSTS_SVH
`define TRPS_CONSTS_SVH

// ----------------------------------------------------------------
// clock and oscillator
// ----------------------------------------------------------------
`define TRPS_CLK_HZ        40000000
`define TRPS_OSC_HZ        200000
`define TRPS_OSC_CYC       (`TRPS_CLK_HZ / `TRPS_OSC_HZ)
`define TRPS_MAX_DUTY_PCT  95
`define TRPS_MAX_DUTY_CYC  ((`TRPS_OSC_CYC * `TRPS_MAX_DUTY_PCT) / 100)

// ----------------------------------------------------------------
// dead time: longest figure rounded down, still above the least
// ----------------------------------------------------------------
`define TRPS_DEAD_MIN_NS   25
`define TRPS_DEAD_MAX_NS   60
`define TRPS_DEAD_CYC      ((`TRPS_DEAD_MAX_NS * (`TRPS_CLK_HZ / 1000000)) / 1000)

// ----------------------------------------------------------------
// soft-start and reference settling
// ----------------------------------------------------------------
`define TRPS_SS_MS         4
`define TRPS_SS_CYC        (`TRPS_SS_MS * (`TRPS_CLK_HZ / 1000))
`define TRPS_REF_SETTLE    8
`define TRPS_SYNC_W        18

`endif

// >>> include/trps_pkg.sv
/*
 * types of the triple-rail pwm sequencer: state enums and the
 * packed state records of the top and of one channel.
 */
package trps_pkg;

  // ----------------------------------------------------------------
  // channel switching phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CH_IDLE, CH_LEAD, CH_HIGH, CH_TRAIL, CH_LOW} trps_phase_e;

  // ----------------------------------------------------------------
  // power-up sequencer phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_OFF, SEQ_REF, SEQ_RUN} trps_seq_e;

  typedef struct packed {
    trps_phase_e st;         // switching phase
    logic [1:0]  dt_cnt;     // dead-time counter
    logic [7:0]  on_cnt;     // cycles since last tick
    logic [7:0]  ss_level;   // soft-start on-time cap
    logic [19:0] ss_pre;     // soft-start step prescaler
    logic        hi;         // high gate command
    logic        lo;         // low gate command
    logic        pulse_skip_state;        // pulse-skip state
    logic        skip;       // last tick was skipped
  } trps_chan_s;

  typedef struct packed {
    logic [17:0] sync1;      // first sync stage
    logic [17:0] sync2;      // second sync stage
    trps_seq_e   seq;        // power-up phase
    logic [3:0]  ref_cnt;    // reference settle count
    logic [7:0]  osc_cnt;    // oscillator divider
    logic        tick;       // oscillator rising edge
    logic        ref_en;     // reference enabled
    logic        osc_run;    // oscillator running
    logic        vl_sw;      // logic rail from mid converter
  } trps_top_s;

endpackage

// >>> rtl/trps_chan.sv
/*
 * one switching channel: buck with dead time, or in-phase boost.
 * assumes synchronised comparators, a one-cycle tick and a raw
 * current-limit level that may arrive at any time.
 */
`timescale 1ns/1ps
`include "trps_consts.svh"
module trps_chan
  import trps_pkg::*;
#(
  parameter bit IS_BOOST = 1'b0,
  parameter int SS_CYC   = `TRPS_SS_CYC
) (
  input  wire logic clk_i,          // core clock
  input  wire logic resetn_i,       // sync reset, low
  input  wire logic ce_i,           // clock enable
  input  wire logic run_i,          // enabled and sequenced
  input  wire logic tick_i,         // oscillator edge
  input  wire logic ontime_trip_i,  // pwm on-time end
  input  wire logic skip_trip_i,    // skip-mode peak reached
  input  wire logic limit_sync_i,   // limit, synchronised
  input  wire logic limit_raw_i,    // limit, raw level
  input  wire logic zero_i,         // inductor current zero
  input  wire logic below_i,        // output below regulation
  output logic      hi_o,           // high gate
  output logic      lo_o,           // low gate
  output logic      psm_o           // pulse-skip state
);
  localparam logic [7:0]  MAXD = 8'(`TRPS_MAX_DUTY_CYC);
  localparam logic [1:0]  DEAD = 2'(`TRPS_DEAD_CYC);
  localparam logic [19:0] STEP = 20'(SS_CYC / `TRPS_MAX_DUTY_CYC);

  trps_chan_s r_reg;
  trps_chan_s r_next;
  logic       end_on;               // on-time terminates
  logic       go;                   // tick starts a pulse

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    end_on = limit_sync_i | (r_reg.on_cnt >= r_reg.ss_level) |
             (r_reg.pulse_skip_state ? skip_trip_i : ontime_trip_i);
    go     = 1'b0;
    if (!run_i) begin
      r_next = '0;
    end else begin
      // soft-start ramps the on-time cap up to maximum duty
      if (r_reg.ss_level < MAXD) begin
        if (r_reg.ss_pre >= STEP - 20'h1) begin
          r_next.ss_pre   = '0;
          r_next.ss_level = r_reg.ss_level + 8'h1;
        end else begin
          r_next.ss_pre = r_reg.ss_pre + 20'h1;
        end
      end
      if (r_reg.on_cnt != 8'hff) begin
        r_next.on_cnt = r_reg.on_cnt + 8'h1;
      end
      unique case (r_reg.st)
        CH_IDLE: begin
        end
        CH_LEAD: begin
          r_next.dt_cnt = r_reg.dt_cnt + 2'h1;
          if (r_reg.dt_cnt == DEAD - 2'h1) begin
            r_next.st = CH_HIGH;
            r_next.hi = 1'b1;
          end
        end
        CH_HIGH: begin
          if (end_on) begin
            r_next.hi     = 1'b0;
            r_next.lo     = 1'b0;
            r_next.dt_cnt = '0;
            r_next.st     = IS_BOOST ? CH_IDLE : CH_TRAIL;
          end
        end
        CH_TRAIL: begin
          r_next.dt_cnt = r_reg.dt_cnt + 2'h1;
          if (r_reg.dt_cnt == DEAD - 2'h1) begin
            r_next.st = CH_LOW;
            r_next.lo = 1'b1;
          end
        end
        CH_LOW: begin
          if (zero_i) begin
            r_next.lo  = 1'b0;
            r_next.st  = CH_IDLE;
            r_next.pulse_skip_state = 1'b1;
          end
        end
      endcase
      // a tick closes the old cycle and maybe opens a new one
      if (tick_i) begin
        r_next.on_cnt = '0;
        r_next.dt_cnt = '0;
        r_next.hi     = 1'b0;
        r_next.lo     = 1'b0;
        if (IS_BOOST) begin
          r_next.pulse_skip_state  = r_reg.skip;
          r_next.skip = ~below_i;
          go          = below_i;
        end else begin
          // a zero event in the same cycle still enters skip mode
          if (r_reg.st == CH_LOW && !zero_i) begin
            r_next.pulse_skip_state = 1'b0;
          end
          go = ~r_next.pulse_skip_state | below_i;
        end
        if (go && IS_BOOST) begin
          r_next.st = CH_HIGH;
          r_next.hi = 1'b1;
          r_next.lo = 1'b1;
        end else begin
          r_next.st = go ? CH_LEAD : CH_IDLE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // state register, frozen while the clock enable is low
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // raw limit cuts the gate at once; a clock edge would be too late
  assign hi_o  = r_reg.hi & ~limit_raw_i;
  assign lo_o  = IS_BOOST ? (r_reg.lo & ~limit_raw_i) : r_reg.lo;
  assign psm_o = r_reg.pulse_skip_state;

endmodule // trps_chan

// >>> verif/trps_top_assertions.sv
/*
 checker of the sequencer top: gate timing, limits, power-up order.
 assumes one clock domain and that it is bound to trps_top.
*/
`timescale 1ns/1ps
module trps_top_assertions #(
  parameter int SS_CYC  = 160000,  // soft-start length
  parameter int REF_CYC = 8      // reference settle
) (
  input wire logic clk_i,                   // core clock
  input wire logic resetn_i,                // sync reset, low
  input wire logic low_rail_enable_i,       // low rail run
  input wire logic mid_rail_enable_i,       // mid rail run
  input wire logic boost_enable_i,          // boost rail run
  input wire logic low_rail_limit_i,        // low rail limit
  input wire logic boost_limit_i,           // boost limit
  input wire logic mid_rail_switchover_i,   // mid above threshold
  input wire logic low_rail_high_gate_o,    // low rail high side
  input wire logic low_rail_low_gate_o,     // low rail low side
  input wire logic mid_rail_high_gate_o,    // mid rail high side
  input wire logic mid_rail_low_gate_o,     // mid rail low side
  input wire logic boost_high_gate_o,       // boost high side
  input wire logic boost_low_gate_o,        // boost low side
  input wire logic reference_enable_o,      // reference on
  input wire logic oscillator_run_o,        // oscillator on
  input wire logic linear_regulator_en_o,   // linear regulator on
  input wire logic logic_supply_rail_sel_o  // rail from converter
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // enables pass two sync stages, so four low samples settle any change
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_LR_BBM: assert property ($fell(low_rail_high_gate_o) |-> !low_rail_low_gate_o [*2])
    else $error("low rail low gate inside dead time");
  AST_LR_LEAD: assert property ($rose(low_rail_high_gate_o) |-> $past(!low_rail_low_gate_o, 2))
    else $error("low rail high gate without dead time");
  AST_MR_BBM: assert property ($rose(mid_rail_low_gate_o) |-> $past(!mid_rail_high_gate_o, 2))
    else $error("mid rail low gate without dead time");
  AST_LR_LIMIT: assert property (low_rail_limit_i |-> !low_rail_high_gate_o)
    else $error("low rail high gate on during limit");
  AST_BOOST_PHASE: assert property (boost_high_gate_o == boost_low_gate_o)
    else $error("boost gates out of phase");
  AST_BOOST_LIMIT: assert property (boost_limit_i |-> !(boost_high_gate_o || boost_low_gate_o))
    else $error("boost gates on during limit");
  AST_LR_ENABLE: assert property (!low_rail_enable_i [*4] |-> !(low_rail_high_gate_o || low_rail_low_gate_o))
    else $error("low rail gate on while disabled");
  AST_SHUTDOWN: assert property (!(low_rail_enable_i || mid_rail_enable_i || boost_enable_i) [*4]
    |-> !(reference_enable_o || oscillator_run_o))
    else $error("reference or oscillator on in shutdown");
  AST_SEQ: assert property ($rose(oscillator_run_o) |-> $past(reference_enable_o, REF_CYC))
    else $error("oscillator started before reference settled");
  AST_RUN_OSC: assert property ((low_rail_high_gate_o || mid_rail_high_gate_o || boost_high_gate_o)
    |-> oscillator_run_o && reference_enable_o)
    else $error("switching without oscillator");
  AST_SWITCH: assert property (mid_rail_switchover_i [*4] |-> logic_supply_rail_sel_o && !linear_regulator_en_o)
    else $error("logic rail not switched over");
endmodule // trps_top_assertions
bind trps_top trps_top_assertions #(.SS_CYC(SS_CYC), .REF_CYC(REF_CYC)) trps_top_assertions_i (.*);

// >>> verif/trps_stage_model.sv
/*
 behavioural power stage and sense comparators of one channel.
 assumes gate levels from the sequencer; current in arbitrary units.
*/
`timescale 1ns/1ps
module trps_stage_model #(
  parameter int ON_LEN   = 40,  // on-time trip after this many cycles
  parameter int SKIP_LEN = 30   // skip peak level
) (
  input  wire logic clk_i,     // core clock
  input  wire logic hi_i,      // high gate
  input  wire logic lo_i,      // low gate, unused: diode path too
  output logic      ontime_o,  // on-time end
  output logic      skip_o,    // skip peak reached
  output logic      zero_o     // inductor current zero
);
  int cur  = 0;  // inductor current
  int hcnt = 0;  // cycles of high gate on
  // current rises while high, decays otherwise so zero ends the low phase
  always @(posedge clk_i) begin
    hcnt <= hi_i ? hcnt + 1 : 0;
    cur  <= hi_i ? cur + 1 : ((cur > 2) ? cur - 2 : 0);
  end
  assign ontime_o = hcnt >= ON_LEN;
  assign skip_o   = cur >= SKIP_LEN;
  assign zero_o   = cur == 0;
endmodule // trps_stage_model

// >>> verif/trps_top_tb_top.sv
/*
 self-checking bench of the sequencer top with stage models.
 assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module trps_top_tb_top;
  logic clk_i = 0, resetn_i = 0, ce_i = 1;
  logic low_rail_enable_i = 0, mid_rail_enable_i = 0, boost_enable_i = 0;
  logic low_rail_limit_i = 0, mid_rail_limit_i = 0, boost_limit_i = 0, mid_rail_switchover_i = 0;
  logic low_rail_below_i = 0, mid_rail_below_i = 0, boost_below_i = 0;
  logic low_rail_ontime_i, low_rail_skip_i, low_rail_zero_i, mid_rail_ontime_i, mid_rail_skip_i;
  logic mid_rail_zero_i, boost_ontime_i, boost_skip_i, reference_enable_o, oscillator_run_o;
  logic low_rail_high_gate_o, low_rail_low_gate_o, mid_rail_high_gate_o, mid_rail_low_gate_o;
  logic boost_high_gate_o, boost_low_gate_o, linear_regulator_en_o, logic_supply_rail_sel_o;
  logic [2:0] pulse_skip_state_o;
  logic       low_skip;  // low rail skip flag
  int         error_cnt = 0, n_tests = 0;
  always_comb low_skip = pulse_skip_state_o[0];
  // short soft-start keeps the run brief
  trps_top #(.SS_CYC(1900)) trps_top_i (.*);
  trps_stage_model trps_stage_model_lo_i (.clk_i(clk_i), .hi_i(low_rail_high_gate_o), .lo_i(low_rail_low_gate_o),
    .ontime_o(low_rail_ontime_i), .skip_o(low_rail_skip_i), .zero_o(low_rail_zero_i));
  trps_stage_model trps_stage_model_mid_i (.clk_i(clk_i), .hi_i(mid_rail_high_gate_o), .lo_i(mid_rail_low_gate_o),
    .ontime_o(mid_rail_ontime_i), .skip_o(mid_rail_skip_i), .zero_o(mid_rail_zero_i));
  trps_stage_model trps_stage_model_bst_i (.clk_i(clk_i), .hi_i(boost_high_gate_o), .lo_i(boost_low_gate_o),
    .ontime_o(boost_ontime_i), .skip_o(boost_skip_i), .zero_o());
  initial forever #12.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task chk(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_on(ref logic s, input logic v, input int lim);
    int n = 0;
    while (s !== v && n < lim) begin
      step(1);
      n++;
    end
    if (s !== v) begin
      error_cnt++;
      $display("[FAIL] %0t wait ran out", $time);
      print_verdict();
    end
  endtask
  // cycles the low rail high gate stays on, bounded
  task automatic hi_width(output int w);
    w = 0;
    while (low_rail_high_gate_o === 1'b1 && w < 400) begin
      step(1);
      w++;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_start;
    int w;
    low_rail_enable_i = 1;
    mid_rail_enable_i = 1;
    wait_on(reference_enable_o, 1, 10);
    chk(oscillator_run_o, 0, "oscillator before reference");
    wait_on(oscillator_run_o, 1, 20);
    wait_on(low_rail_high_gate_o, 1, 3000);
    chk(low_rail_low_gate_o, 0, "low gate with high gate");
    hi_width(w);
    chk(w < 30, 1, "soft-start did not cap on-time");
    wait_on(low_rail_low_gate_o, 1, 400);
    chk(low_rail_high_gate_o, 0, "high gate with low gate");
    $display("test start done");
  endtask
  task t_skip;
    logic seen;
    int   w;
    seen = 0;
    wait_on(low_skip, 1, 3000);
    repeat (400) begin
      step(1);
      seen |= low_rail_high_gate_o | mid_rail_high_gate_o;
    end
    chk(seen, 0, "switched while above regulation");
    chk(pulse_skip_state_o[1], 1, "mid rail not skipping");
    low_rail_below_i = 1;
    mid_rail_below_i = 1;
    wait_on(low_rail_high_gate_o, 1, 210);
    hi_width(w);
    chk(w < 38, 1, "skip trip did not end on-time");
    $display("test skip done");
  endtask
  task t_limit;
    wait_on(low_rail_high_gate_o, 1, 400);
    low_rail_limit_i = 1;
    mid_rail_limit_i = 1;
    #1 chk(low_rail_high_gate_o, 0, "limit did not cut gate");
    chk(mid_rail_high_gate_o, 0, "mid limit did not cut gate");
    step(5);
    low_rail_limit_i = 0;
    mid_rail_limit_i = 0;
    #1 chk(low_rail_high_gate_o, 0, "cycle resumed after limit");
    wait_on(low_rail_high_gate_o, 1, 210);
    $display("test limit done");
  endtask
  task t_switch;
    mid_rail_switchover_i = 1;
    step(4);
    chk(logic_supply_rail_sel_o, 1, "rail not from converter");
    chk(linear_regulator_en_o, 0, "regulator still on");
    mid_rail_switchover_i = 0;
    step(4);
    chk(linear_regulator_en_o, 1, "regulator not back");
    ce_i = 0;
    mid_rail_switchover_i = 1;
    step(3);
    chk(logic_supply_rail_sel_o, 0, "state moved with clock enable low");
    mid_rail_switchover_i = 0;
    ce_i = 1;
    $display("test switch done");
  endtask
  task t_boost;
    boost_enable_i = 1;
    boost_below_i = 1;
    wait_on(boost_high_gate_o, 1, 3000);
    chk(boost_low_gate_o, 1, "boost gates apart");
    wait_on(boost_high_gate_o, 0, 200);
    chk(boost_low_gate_o, 0, "boost low gate stuck");
    wait_on(boost_high_gate_o, 1, 210);
    boost_limit_i = 1;
    #1 chk(boost_low_gate_o, 0, "boost limit ignored");
    step(5);
    boost_limit_i = 0;
    boost_below_i = 0;
    chk(pulse_skip_state_o[2], 0, "boost skipping below regulation");
    step(420);
    chk(pulse_skip_state_o[2], 1, "boost not skipping above regulation");
    chk(boost_high_gate_o, 0, "boost switched above regulation");
    $display("test boost done");
  endtask
  task t_off;
    low_rail_enable_i = 0;
    step(4);
    chk(low_rail_high_gate_o | low_rail_low_gate_o, 0, "disabled rail switching");
    chk(oscillator_run_o, 1, "oscillator stopped early");
    mid_rail_enable_i = 0;
    boost_enable_i = 0;
    step(4);
    chk(reference_enable_o | oscillator_run_o, 0, "no shutdown");
    $display("test off done");
  endtask
  initial begin
    step(5);
    resetn_i = 1;
    chk(linear_regulator_en_o, 1, "regulator off after reset");
    t_start;
    t_skip;
    t_limit;
    t_switch;
    t_boost;
    t_off;
    print_verdict;
  end
endmodule // trps_top_tb_top
